/* File: nps_seq.v */
// programming sequencer for the code flash and data eeprom arrays
// assumes all pin inputs are asynchronous to CLK and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "nps_seq_defs.vh"

module nps_seq #(
  parameter [19:0] PWRITE_CYC = `NPS_PWRITE_CYC,
  parameter [19:0] HOLD_CYC   = `NPS_HOLD_CYC,
  parameter [19:0] SERASE_CYC = `NPS_SERASE_CYC,
  parameter [19:0] SWRITE_CYC = `NPS_SWRITE_CYC
) (
  // clock and reset
  input  wire        CLK,
  input  wire        ARST_N,
  // parallel programming pins
  input  wire        RESET_PIN,
  input  wire        PROGRAM_STORE_ENABLE_N,
  input  wire        HIGH_VOLTAGE_ENABLE,
  input  wire        PROG_STROBE_N,
  input  wire        MODE_SELECT_A,
  input  wire        MODE_SELECT_B,
  input  wire        MODE_SELECT_C,
  input  wire        MODE_SELECT_D,
  input  wire [13:0] ADDR_PIN,
  input  wire [7:0]  DATA_I,
  output reg  [7:0]  DATA_O,
  output reg  [7:0]  DATA_OE_N,
  output reg         PROGRESS_PIN,
  // serial programming pins
  input  wire        SCK,
  input  wire        MOSI,
  output reg         MISO,
  // axi4-lite write channels
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  // axi4-lite read channels
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_WRITE = 2'd1;
  localparam [1:0] ST_ERASE = 2'd2;

  reg  [31:0] sync1_q;
  reg  [31:0] sync2_q;
  reg         prog_prev_q;
  reg         sck_prev_q;
  reg  [1:0]  st_q;
  reg  [19:0] cnt_q;
  reg  [19:0] hold_q;
  reg         hold_done_q;
  reg         ser_en_q;
  reg         fuse_q;        // 1 = serial programming blocked
  reg  [2:0]  lock_q;        // 1 = programmed, bit0 is lock_bit_one
  reg  [13:0] last_a_q;
  reg  [7:0]  last_d_q;
  reg         mem_we_q;
  reg         mem_clr_q;
  reg  [4:0]  bit_cnt_q;
  reg  [23:0] sh_q;
  reg  [7:0]  tx_q;
  reg         ctrl_en_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [7:0]  awa_q;
  reg  [31:0] wd_q;
  reg         wstb_q;
  reg  [7:0]  mem [0:`NPS_MEM_WORDS-1];
  reg  [7:0]  par_rd;
  reg         par_rd_en;
  integer     i;

  // synchronised pin view
  wire        rst_pin  = sync2_q[31];
  wire        program_store_enable_n   = sync2_q[30];
  wire        hv_en    = sync2_q[29];
  wire        prog_n   = sync2_q[28];
  wire [3:0]  mode_sel = sync2_q[27:24];
  wire        sck      = sync2_q[23];
  wire        mosi     = sync2_q[22];
  wire [13:0] par_a    = sync2_q[21:8];
  wire [7:0]  par_d    = sync2_q[7:0];

  wire        par_act  = rst_pin & ~program_store_enable_n & hv_en & ctrl_en_q;
  wire        ser_act  = rst_pin & program_store_enable_n & ctrl_en_q & ~fuse_q;
  wire        prog_rise = par_act & ~prog_prev_q & prog_n;
  wire        sck_rise  = ser_act & ~sck_prev_q & sck;
  wire        sck_fall  = ser_act & sck_prev_q & ~sck;
  wire [23:0] sh_nx     = {sh_q[22:0], mosi};
  wire [7:0]  b1        = sh_nx[23:16];
  wire [7:0]  b2        = sh_nx[15:8];
  wire [7:0]  b3        = sh_nx[7:0];
  wire        idle      = (st_q == ST_IDLE);

  // byte returned by any array read, with polling and protection applied
  function [7:0] arr_rd;
    input [13:0] a;
    begin
      if (lock_q[0] && lock_q[1])
        arr_rd = `NPS_ERASED;
      // [RL7] polling read of the byte being written
      else if (st_q == ST_WRITE && a == last_a_q)
        arr_rd = {~last_d_q[7], last_d_q[6:0]};
      else
        arr_rd = mem[a];
    end
  endfunction

  // linear array index of a serial address, opcode low bit 2 picks data
  function [13:0] ser_addr;
    input [7:0] op;
    input [7:0] lo;
    begin
      if (op[2])
        ser_addr = `NPS_DATA_BASE | {3'h0, op[5:3], lo};
      else
        ser_addr = `NPS_CODE_BASE | {1'b0, op[7:3], lo};
    end
  endfunction

  // two-stage synchroniser for every pin input
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q     <= `NPS_SYNC_RST;
      sync2_q     <= `NPS_SYNC_RST;
      prog_prev_q <= 1'b1;
      sck_prev_q  <= 1'b0;
    end else begin
      sync1_q     <= {RESET_PIN, PROGRAM_STORE_ENABLE_N, HIGH_VOLTAGE_ENABLE, PROG_STROBE_N,
                      MODE_SELECT_A, MODE_SELECT_B, MODE_SELECT_C, MODE_SELECT_D,
                      SCK, MOSI, ADDR_PIN, DATA_I};
      sync2_q     <= sync1_q;
      prog_prev_q <= prog_n;
      sck_prev_q  <= sck;
    end
  end

  // array storage, no reset; cleared only by chip erase
  always @(posedge CLK) begin
    if (mem_clr_q) begin
      for (i = 0; i < `NPS_MEM_WORDS; i = i + 1)
        mem[i] <= `NPS_ERASED;
    end else if (mem_we_q) begin
      mem[last_a_q] <= last_d_q;
    end
  end

  // parallel read decode
  always @* begin
    par_rd    = 8'h00;
    par_rd_en = par_act & prog_n;
    case (mode_sel)
      // [RL1] one linear space
      `NPS_M_READ: begin
        if (par_a < `NPS_MEM_END)
          par_rd = arr_rd(par_a);
        else
          par_rd = `NPS_ERASED;
      end
      // [RL9] direct lock readback
      `NPS_M_LOCK_RD: par_rd = {5'h00, lock_q[0], lock_q[1], lock_q[2]};
      // [RL14] identification bytes
      `NPS_M_SIG: begin
        if (par_a == `NPS_SIG_ADDR0)
          par_rd = `NPS_SIG_BYTE0;    // maker code
        else if (par_a == `NPS_SIG_ADDR1)
          par_rd = `NPS_SIG_BYTE1;    // part code
        else
          par_rd = 8'h00;
      end
      `NPS_M_FUSE_RD: par_rd = {7'h00, fuse_q};
      default: par_rd_en = 1'b0;
    endcase
  end

  // sequencer: parallel strobes, serial instructions and self-timing
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q         <= ST_IDLE;
      cnt_q        <= 20'h00000;
      hold_q       <= 20'h00000;
      hold_done_q  <= 1'b0;
      ser_en_q     <= 1'b0;
      fuse_q       <= 1'b0;
      lock_q       <= 3'h0;
      last_a_q     <= 14'h0000;
      last_d_q     <= 8'h00;
      mem_we_q     <= 1'b0;
      mem_clr_q    <= 1'b0;
      bit_cnt_q    <= 5'h00;
      sh_q         <= 24'h000000;
      tx_q         <= 8'h00;
      MISO         <= 1'b0;
      PROGRESS_PIN <= 1'b1;
      DATA_O       <= 8'h00;
      DATA_OE_N    <= 8'hFF;
    end else begin
      mem_we_q  <= 1'b0;
      mem_clr_q <= 1'b0;
      DATA_O    <= par_rd;
      // [RL6] data port driven for verify reads
      DATA_OE_N <= par_rd_en ? 8'h00 : 8'hFF;
      // self-timed cycle countdown
      if (!idle) begin
        if (cnt_q == 20'h00001) begin
          if (st_q == ST_ERASE) begin
            // [RL11] erase ends with all ones
            mem_clr_q <= 1'b1;
            lock_q    <= 3'h0;
          end
          st_q <= ST_IDLE;
        end
        cnt_q <= cnt_q - 20'h00001;
      end
      // [RL8] progress low while busy
      PROGRESS_PIN <= idle;
      if (!idle && cnt_q == 20'h00001)
        PROGRESS_PIN <= 1'b1;
      // parallel strobe hold timing for erase and fuse
      if (!par_act || prog_n) begin
        hold_q      <= 20'h00000;
        hold_done_q <= 1'b0;
      end else if (!hold_done_q && idle) begin
        hold_q <= hold_q + 20'h00001;
        if (hold_q == HOLD_CYC - 20'h00001) begin
          hold_done_q <= 1'b1;
          // [RL10] long strobe chip erase
          if (mode_sel == `NPS_M_ERASE) begin
            mem_clr_q <= 1'b1;
            lock_q    <= 3'h0;
          end
          // [RL13] fuse changed in parallel mode
          if (mode_sel == `NPS_M_FUSE_WR)
            fuse_q <= par_d[0];
        end
      end
      // [RL5] single strobe starts a timed write
      if (prog_rise && idle && mode_sel == `NPS_M_WRITE && !lock_q[0]
          && par_a < `NPS_MEM_END) begin
        mem_we_q <= 1'b1;
        last_a_q <= par_a;
        last_d_q <= par_d;
        st_q     <= ST_WRITE;
        cnt_q    <= PWRITE_CYC;
        PROGRESS_PIN <= 1'b0;
      end
      if (prog_rise && idle && mode_sel == `NPS_M_LOCK_WR) begin
        lock_q <= lock_q | ~{par_d[5], par_d[6], par_d[7]};
        st_q   <= ST_WRITE;
        cnt_q  <= PWRITE_CYC;
        PROGRESS_PIN <= 1'b0;
      end
      // serial shift engine
      if (!ser_act) begin
        bit_cnt_q <= 5'h00;
        tx_q      <= 8'h00;
        MISO      <= 1'b0;
        if (!rst_pin)
          ser_en_q <= 1'b0;
      end else begin
        // [RL24] msb first, sampled on rising edge
        if (sck_rise) begin
          sh_q      <= sh_nx;
          bit_cnt_q <= (bit_cnt_q == `NPS_BITS_LAST) ? 5'h00 : bit_cnt_q + 5'h01;
          if (bit_cnt_q == `NPS_BITS_READ) begin
            if (!ser_en_q)
              tx_q <= 8'h00;
            // [RL12] zero during erase
            else if (st_q == ST_ERASE)
              tx_q <= 8'h00;
            // [RL20] [RL21] reads return on byte three
            else if (b2[2:0] == `NPS_OP_RD_CODE
                     || (b2[2:0] == `NPS_OP_RD_DATA && b2[7:6] == 2'b00))
              tx_q <= arr_rd(ser_addr(b2, b3));
            else
              tx_q <= 8'h00;
          end
          if (bit_cnt_q == `NPS_BITS_LAST) begin
            // [RL18] enable instruction
            if (b1 == `NPS_OP_PREFIX && b2 == `NPS_OP_ENABLE)
              ser_en_q <= 1'b1;
            // [RL15] nothing else until enabled
            else if (ser_en_q && idle) begin
              if (b1 == `NPS_OP_PREFIX) begin
                // [RL19] chip erase instruction
                if (b2[2:0] == `NPS_OP2_ERASE) begin
                  st_q  <= ST_ERASE;
                  cnt_q <= SERASE_CYC;
                end
                // [RL22] zero fields program lock bits
                if (b2[2:0] == `NPS_OP2_LOCK)
                  lock_q <= lock_q | ~b2[7:5];
              // [RL3] [RL17] auto-erase timed write
              end else if (!lock_q[0] && (b1[2:0] == `NPS_OP_WR_CODE
                          || (b1[2:0] == `NPS_OP_WR_DATA && b1[7:6] == 2'b00))) begin
                // [RL2] opcode picks array
                mem_we_q <= 1'b1;
                last_a_q <= ser_addr(b1, b2);
                last_d_q <= b3;
                st_q     <= ST_WRITE;
                cnt_q    <= SWRITE_CYC;
              end
              // [RL25] other opcodes fall through unchanged
            end
          end
        end
        // [RL24] output shifts on falling edge
        if (sck_fall) begin
          MISO <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // axi4-lite slave
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AWREADY   <= 1'b1;
      WREADY    <= 1'b1;
      BVALID    <= 1'b0;
      BRESP     <= `NPS_RESP_OKAY;
      ARREADY   <= 1'b1;
      RVALID    <= 1'b0;
      RRESP     <= `NPS_RESP_OKAY;
      RDATA     <= 32'h00000000;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h00000000;
      wstb_q    <= 1'b0;
      ctrl_en_q <= `NPS_CTRL_RESET;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_q <= 1'b1;
        awa_q     <= AWADDR;
        AWREADY   <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_q <= 1'b1;
        wd_q     <= WDATA;
        wstb_q   <= WSTRB[0];
        WREADY   <= 1'b0;
      end
      if (BVALID && BREADY)
        BVALID <= 1'b0;
      // write commits once both halves are held
      if (aw_have_q && w_have_q && !BVALID) begin
        BVALID    <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        AWREADY   <= 1'b1;
        WREADY    <= 1'b1;
        if (awa_q[7:2] == `NPS_REG_CTRL >> 2) begin
          BRESP <= `NPS_RESP_OKAY;
          if (wstb_q)
            ctrl_en_q <= wd_q[0];
        end else if (awa_q[7:2] == `NPS_REG_STATUS >> 2
                     || awa_q[7:2] == `NPS_REG_LAST >> 2)
          BRESP <= `NPS_RESP_OKAY;
        else
          BRESP <= `NPS_RESP_SLVERR;
      end
      // read answers one cycle after the address is taken
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RRESP   <= `NPS_RESP_OKAY;
        case (ARADDR[7:2])
          `NPS_REG_STATUS >> 2:
            RDATA <= {22'h000000, ser_act, par_act, lock_q, fuse_q, ser_en_q, 1'b0,
                      st_q == ST_ERASE, ~idle};
          `NPS_REG_CTRL >> 2:   RDATA <= {31'h00000000, ctrl_en_q};
          `NPS_REG_LAST >> 2:   RDATA <= {10'h000, last_a_q, last_d_q};
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= `NPS_RESP_SLVERR;
          end
        endcase
      end
      if (RVALID && RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule // nps_seq

`default_nettype wire

/* File: nps_seq_bench.sv */
// self-checking bench for the programming sequencer
// drives parallel pins and the register port; serial via nps_ser_prog
`timescale 1ns/100ps
`default_nettype none
`include "nps_seq_defs.vh"
module nps_seq_bench;
  localparam [7:0] SIG0 = 8'h5A; // arbitrary value
  localparam [7:0] SIG1 = 8'hA5; // arbitrary value
  logic CLK, ARST_N, RESET_PIN, PROGRAM_STORE_ENABLE_N, HIGH_VOLTAGE_ENABLE, PROG_STROBE_N;
  logic MODE_SELECT_A, MODE_SELECT_B, MODE_SELECT_C, MODE_SELECT_D, PROGRESS_PIN;
  logic SCK, MOSI, MISO, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, sreq, sdone;
  logic [13:0] ADDR_PIN;
  logic [7:0]  DATA_I, DATA_O, DATA_OE_N, AWADDR, ARADDR, srd, b;
  logic [31:0] WDATA, RDATA, w;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, r;
  logic [23:0] sins;
  int          fail_count = 0, check_count = 0, cyc = 0;
  nps_seq #(.PWRITE_CYC(20'd60), .HOLD_CYC(20'd20), .SERASE_CYC(20'd900),
    .SWRITE_CYC(20'd20)) i_nps_seq (.*);
  nps_ser_prog i_nps_ser_prog (.req(sreq), .instr(sins), .done(sdone), .rbyte(srd),
    .sck(SCK), .mosi(MOSI), .miso(MISO));
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int n = 0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 50);
    rsp = BRESP;
    BREADY <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int n = 0;
    @(posedge CLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 50);
    d = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  // sets mode, address, data; strobes low for lo cycles when lo > 0
  task automatic par(input logic [3:0] m, input logic [13:0] a, input logic [7:0] d,
                     input int lo);
    @(posedge CLK);
    {MODE_SELECT_A, MODE_SELECT_B, MODE_SELECT_C, MODE_SELECT_D} <= m;
    ADDR_PIN <= a;
    DATA_I <= d;
    repeat (4) @(posedge CLK);
    if (lo > 0) begin
      PROG_STROBE_N <= 1'b0;
      repeat (lo) @(posedge CLK);
      PROG_STROBE_N <= 1'b1;
    end
    repeat (6) @(posedge CLK);
  endtask
  task automatic wait_rdy;
    int n = 0;
    while (PROGRESS_PIN !== 1'b1 && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 5000) fail_count++;
  endtask
  task automatic ser(input logic [23:0] ins, output logic [7:0] rd);
    int n = 0;
    @(posedge CLK);
    sins <= ins;
    sreq <= 1'b1;
    while (sdone !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    rd = srd;
    sreq <= 1'b0;
    if (n >= 2000) fail_count++;
  endtask
  // main sequence
  initial begin
    {ARST_N, PROGRAM_STORE_ENABLE_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, sreq} = '0;
    {RESET_PIN, HIGH_VOLTAGE_ENABLE, PROG_STROBE_N} = 3'h7;
    {MODE_SELECT_A, MODE_SELECT_B, MODE_SELECT_C, MODE_SELECT_D} = 4'hF;
    {ADDR_PIN, DATA_I, AWADDR, ARADDR, WDATA, sins} = '0;
    WSTRB = 4'hF;
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    axi_rd(`NPS_REG_CTRL, w, r);
    cmp32(w & 32'h1, 32'h1);
    axi_rd(8'h0C, w, r);
    cmp8({6'h0, r}, {6'h0, `NPS_RESP_SLVERR});
    axi_wr(8'h0C, 32'h0, r);
    cmp8({6'h0, r}, {6'h0, `NPS_RESP_SLVERR});
    axi_wr(`NPS_REG_CTRL, 32'h1, r);
    cmp8({6'h0, r}, {6'h0, `NPS_RESP_OKAY});
    par(`NPS_M_ERASE, 14'h0, 8'h0, 40);
    wait_rdy();
    par(`NPS_M_READ, 14'h27FF, 8'h0, 0);
    cmp8(DATA_O, 8'hFF);
    cmp8(DATA_OE_N, 8'h00);
    par(`NPS_M_WRITE, 14'h2005, 8'h3C, 4);
    par(`NPS_M_READ, 14'h2005, 8'h0, 0);
    cmp8(DATA_O, 8'hBC);
    cmp8({7'h0, PROGRESS_PIN}, 8'h0);
    wait_rdy();
    par(`NPS_M_READ, 14'h2005, 8'h0, 0);
    cmp8(DATA_O, 8'h3C);
    axi_rd(`NPS_REG_LAST, w, r);
    cmp32(w, 32'h0020053C);
    par(`NPS_M_SIG, 14'h0030, 8'h0, 0);
    cmp8(DATA_O, SIG0);
    par(`NPS_M_SIG, 14'h0031, 8'h0, 0);
    cmp8(DATA_O, SIG1);
    // fuse set in parallel mode keeps the serial side dead
    par(`NPS_M_FUSE_WR, 14'h0, 8'h01, 40);
    par(`NPS_M_FUSE_RD, 14'h0, 8'h0, 0);
    cmp8(DATA_O, 8'h01);
    PROGRAM_STORE_ENABLE_N <= 1'b1;
    ser(24'hAC5300, b);
    axi_rd(`NPS_REG_STATUS, w, r);
    cmp32(w, 32'h00000010);
    PROGRAM_STORE_ENABLE_N <= 1'b0;
    par(`NPS_M_FUSE_WR, 14'h0, 8'h00, 40);
    PROGRAM_STORE_ENABLE_N <= 1'b1;
    ser(24'h0A2355, b);
    ser(24'hAC5300, b);
    ser(24'h092300, b);
    cmp8(b, 8'hFF);
    ser(24'h050500, b);
    cmp8(b, 8'h3C);
    ser(24'h0A2355, b);
    ser(24'h092300, b);
    cmp8(b, 8'h55);
    ser(24'h0A23AA, b);
    ser(24'h092300, b);
    cmp8(b, 8'hAA);
    ser(24'h3EFF99, b);
    ser(24'h3DFF00, b);
    cmp8(b, 8'h99);
    ser(24'h39FF00, b);
    cmp8(b, 8'hFF);
    ser(24'h082311, b);
    ser(24'h092300, b);
    cmp8(b, 8'hAA);
    ser(24'hAC9F00, b);
    ser(24'h092300, b);
    cmp8(b, 8'hFF);
    ser(24'hAC0400, b);
    ser(24'h092300, b);
    cmp8(b, 8'h00);
    axi_rd(`NPS_REG_STATUS, w, r);
    cmp32(w, 32'h0000026B);
    wait_rdy();
    ser(24'h092300, b);
    cmp8(b, 8'hFF);
    ser(24'h021012, b);
    ser(24'h011000, b);
    cmp8(b, 8'h12);
    results();
  end
endmodule // nps_seq_bench
`default_nettype wire

/* File: nps_seq_defs.vh */
// constants for the flash and eeprom programming sequencer
// assumes a 40 MHz system clock and an AXI4-Lite register port with 8-bit addresses
// What this block does
// [RL1] parallel mode: code at 0000H-1FFFH, data follows at 2000H-27FFH
// [RL2] serial mode: code 0000H-1FFFH and data 000H-7FFH chosen by opcode
// [RL3] serial write auto-erases its byte; chip erase needed only once locked
// [RL4] parallel mode has no auto-erase; programmer chip-erases before rewriting; the code's parallel write replaces the byte as the serial write does
// [RL5] one parallel strobe pulse writes one byte, self-timed about 1.5 ms
// [RL6] programmer verifies by dropping mode line b and reading the data port
// [RL7] reading the last written byte while busy returns inverted bit 7
// [RL8] progress output goes low after strobe rises, high when write ends
// [RL9] array read-back only while lock bits one and two unprogrammed; code blocks it only once both are programmed
// [RL10] strobe held low 10 ms in erase mode sets both arrays to ones
// [RL11] serial chip erase is self-timed about 16 ms, then all FFH
// [RL12] serial reads during a chip erase return 00H
// [RL13] serial fuse blocks serial programming; changed only in parallel mode
// [RL14] identification bytes read at 030H and 031H with lines c, d low
// [RL15] serial programming enable must precede program or erase instructions
// [RL16] programmer keeps shift clock below oscillator frequency over forty; bench model nps_ser_prog shifts at 5 MHz, an eighth of 40 MHz
// [RL17] serial byte write finishes within 2.5 ms at 5 V
// [RL18] three-byte instructions; enable is ACH, 53H, don't-care
// [RL19] chip erase is ACH then second byte with low bits 100
// [RL20] code read aaaaa001, code write aaaaa010, byte two low address
// [RL21] data read 00aaa101, data write 00aaa110, byte two low address
// [RL22] lock write ACH; each lock field given zero becomes programmed
// [RL23] parallel write mode is L H H H, read mode L L H H
// [RL24] serial bytes shift most significant bit first, one bit per clock
// [RL25] undefined serial opcodes are ignored with no state change
`ifndef NPS_SEQ_DEFS_VH
`define NPS_SEQ_DEFS_VH

// memory map
`define NPS_MEM_WORDS     10240
`define NPS_CODE_BASE     14'h0000
`define NPS_DATA_BASE     14'h2000
`define NPS_MEM_END       14'h2800
`define NPS_ERASED        8'hFF
`define NPS_SIG_ADDR0     14'h0030
`define NPS_SIG_ADDR1     14'h0031
`define NPS_SIG_BYTE0     8'h5A        // arbitrary value
`define NPS_SIG_BYTE1     8'hA5        // arbitrary value
// synchroniser reset: strobe pin idles high, so no false rise after reset
`define NPS_SYNC_RST      32'h10000000

// mode-select codes {a,b,c,d}
`define NPS_M_ERASE       4'h8
`define NPS_M_WRITE       4'h7
`define NPS_M_READ        4'h3
`define NPS_M_LOCK_WR     4'hA
`define NPS_M_LOCK_RD     4'hC
`define NPS_M_SIG         4'h0
`define NPS_M_FUSE_WR     4'h5
`define NPS_M_FUSE_RD     4'hD

// serial instruction codes
`define NPS_OP_PREFIX     8'hAC
`define NPS_OP_ENABLE     8'h53
`define NPS_OP2_ERASE     3'h4
`define NPS_OP2_LOCK      3'h7
`define NPS_OP_RD_CODE    3'h1
`define NPS_OP_WR_CODE    3'h2
`define NPS_OP_RD_DATA    3'h5
`define NPS_OP_WR_DATA    3'h6
`define NPS_BITS_LAST     5'd23
`define NPS_BITS_READ     5'd15

// timing, microseconds and derived cycles
`define NPS_CLK_MHZ       40
`define NPS_T_PWRITE_US   1500
`define NPS_T_HOLD_US     10000
`define NPS_T_SERASE_US   16000
`define NPS_T_SWRITE_US   2500
`define NPS_PWRITE_CYC    (`NPS_T_PWRITE_US * `NPS_CLK_MHZ)
`define NPS_HOLD_CYC      (`NPS_T_HOLD_US * `NPS_CLK_MHZ)
`define NPS_SERASE_CYC    (`NPS_T_SERASE_US * `NPS_CLK_MHZ)
`define NPS_SWRITE_CYC    (`NPS_T_SWRITE_US * `NPS_CLK_MHZ)

// register map
`define NPS_REG_STATUS    8'h00
`define NPS_REG_CTRL      8'h04
`define NPS_REG_LAST      8'h08
`define NPS_CTRL_RESET    1'b1
`define NPS_RESP_OKAY     2'b00
`define NPS_RESP_SLVERR   2'b10

`endif

/* File: nps_seq_props.sv */
// assertions on the sequencer pins and register port
// bound to nps_seq; sees only its ports, timing counts handed on
`timescale 1ns/100ps
`default_nettype none
`include "nps_seq_defs.vh"
module nps_seq_props #(
  parameter [19:0] PWRITE_CYC = 20,
  parameter [19:0] HOLD_CYC   = 20,
  parameter [19:0] SERASE_CYC = 20,
  parameter [19:0] SWRITE_CYC = 20
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        ARST_N,
  // parallel pins
  input wire logic        RESET_PIN,
  input wire logic        PROGRAM_STORE_ENABLE_N,
  input wire logic        HIGH_VOLTAGE_ENABLE,
  input wire logic        PROG_STROBE_N,
  input wire logic        MODE_SELECT_A,
  input wire logic        MODE_SELECT_B,
  input wire logic        MODE_SELECT_C,
  input wire logic        MODE_SELECT_D,
  input wire logic [7:0]  DATA_OE_N,
  input wire logic        PROGRESS_PIN,
  // serial pins
  input wire logic        SCK,
  input wire logic        MISO,
  // register port
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY
);
  localparam int LIMIT = PWRITE_CYC + HOLD_CYC + SERASE_CYC + SWRITE_CYC + 16;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire       par_on = RESET_PIN && !PROGRAM_STORE_ENABLE_N && HIGH_VOLTAGE_ENABLE;
  wire [3:0] mode   = {MODE_SELECT_A, MODE_SELECT_B, MODE_SELECT_C, MODE_SELECT_D};
  logic [23:0] busy_q;
  // counts cycles of one busy period
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) busy_q <= '0;
    else busy_q <= PROGRESS_PIN ? '0 : busy_q + 24'h1;
  end
  sequence s_wr_pulse;
    par_on && mode == `NPS_M_WRITE && PROGRESS_PIN ##1 $rose(PROG_STROBE_N);
  endsequence
  sequence s_read_mode;
    (par_on && mode == `NPS_M_READ && PROG_STROBE_N) [*6];
  endsequence
  chk_busy_after:
    assert property (s_wr_pulse |-> ##[1:6] !PROGRESS_PIN) else $error("no busy after strobe");
  chk_busy_bound:
    assert property (busy_q <= LIMIT) else $error("busy period too long");
  chk_read_drive:
    assert property (s_read_mode |-> DATA_OE_N == 8'h00) else $error("data port not driven");
  chk_ser_float:
    assert property (PROGRAM_STORE_ENABLE_N [*6] |-> DATA_OE_N == 8'hFF)
      else $error("data port driven in serial mode");
  chk_miso_edge:
    assert property ($changed(MISO) |-> !SCK) else $error("output moved while clock high");
  chk_b_hold:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("b dropped");
  chk_b_order:
    assert property ($rose(BVALID) |-> !$past(AWREADY) && !$past(WREADY))
      else $error("response before take");
  chk_r_hold:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("r dropped");
  chk_r_answer:
    assert property (ARVALID && ARREADY |=> RVALID && !ARREADY) else $error("late read answer");
  chk_r_unmapped:
    assert property (ARVALID && ARREADY && ARADDR == 8'h0C |=>
      RRESP == `NPS_RESP_SLVERR && RDATA == 32'h0) else $error("unmapped read accepted");
endmodule // nps_seq_props
bind nps_seq nps_seq_props #(.PWRITE_CYC(PWRITE_CYC), .HOLD_CYC(HOLD_CYC),
  .SERASE_CYC(SERASE_CYC), .SWRITE_CYC(SWRITE_CYC)) i_nps_seq_props (.*);
`default_nettype wire

/* File: nps_ser_prog.sv */
// serial programmer model: shifts one 24-bit instruction per request
// assumes req rises with instr stable and falls after done
`timescale 1ns/100ps
`default_nettype none
module nps_ser_prog (
  // request side
  input  wire logic        req,
  input  wire logic [23:0] instr,
  output var  logic        done,
  output var  logic [7:0]  rbyte,
  // serial pins
  output var  logic        sck,
  output var  logic        mosi,
  input  wire logic        miso
);
  int i;
  // shift clock of 200 ns period, idle low between frames
  initial begin
    done = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
    rbyte = 8'h00;
    forever begin
      @(posedge req);
      #5; // keep pin changes off the system clock edge
      for (i = 23; i >= 0; i--) begin
        mosi = instr[i];
        #100 sck = 1'b1;
        rbyte = {rbyte[6:0], miso};
        #100 sck = 1'b0;
      end
      mosi = ~mosi; // idle line shows no stale bit
      done = 1'b1;
      @(negedge req);
      done = 1'b0;
    end
  end
endmodule // nps_ser_prog
`default_nettype wire
